// ===== common/fsp_regs.svh
// register offsets, field positions, reset values and timing counts of the status poller
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// ----------------
// register offsets (byte addresses, one aligned word each)
// ----------------
`define FSP_OFF_CMD 8'h00
`define FSP_OFF_ADDR_A 8'h04
`define FSP_OFF_ADDR_B 8'h08
`define FSP_OFF_DATA 8'h0c
`define FSP_OFF_STATUS 8'h10
`define FSP_OFF_IRQ_STAT 8'h14
`define FSP_OFF_IRQ_MASK 8'h18

// ----------------
// command register fields and codes
// ----------------
`define FSP_CMD_OP_LSB 0
`define FSP_CMD_MODE_LSB 2
`define FSP_CMD_PD_LSB 4
`define FSP_OP_POLL 2'h1
`define FSP_OP_WRITE 2'h2
`define FSP_MODE_SINGLE 2'h0
`define FSP_MODE_MULTI 2'h1
`define FSP_MODE_WBUF 2'h2
`define FSP_PD_NONE 2'h0
`define FSP_PD_ENTRY 2'h1
`define FSP_PD_RELEASE 2'h2

// ----------------
// status and interrupt fields
// ----------------
`define FSP_ST_BUSY 0
`define FSP_ST_TOGGLE 1
`define FSP_ST_SECT_TOGGLE 2
`define FSP_ST_TIMEOUT 3
`define FSP_ST_BYTE_LSB 8
`define FSP_IRQ_PASS 0
`define FSP_IRQ_FAIL 1
`define FSP_IRQ_ABORT 2
`define FSP_IRQ_CMD_DONE 3
`define FSP_RST_WORD 32'h0000_0000
`define FSP_RST_IRQ 4'h0

// ----------------
// status byte bit positions
// ----------------
`define FSP_BIT_DATA_POLL 7
`define FSP_BIT_TOGGLE 6
`define FSP_BIT_TIMEOUT 5
`define FSP_BIT_SECT_TOGGLE 2
`define FSP_BIT_BUF_ABORT 1

// ----------------
// timing
// ----------------
`define FSP_CLK_MHZ 25
`define FSP_TDP_MAX_NS 20000
`define FSP_TRDP_MAX_NS 200000
`define FSP_TDP_CYC ((`FSP_TDP_MAX_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_TRDP_CYC ((`FSP_TRDP_MAX_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_RD_ACC_CYC 4'h4
`define FSP_WE_LOW_CYC 4'h3

`endif

// ===== common/fsp_pkg.sv
// types shared by the status poller and its flash bus cycle engine
package fsp_pkg;

    localparam int AW = 25;
    localparam int DW = 16;

    // ----------------
    // carriers
    // ----------------
    typedef struct packed {
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_o;
        logic dq_oe;
    } fsp_pins_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } fsp_req_t;

    // ----------------
    // states
    // ----------------
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_ACTIVE,
        CYC_RECOVER
    } fsp_cyc_state_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POLL,
        ST_RECHK,
        ST_CMD,
        ST_PD_WAIT
    } fsp_state_t;

endpackage : fsp_pkg

// ===== rtl/fsp_bus_cycle.sv
// one asynchronous flash read or write cycle, timed in clock counts
`include "fsp_regs.svh"

module fsp_bus_cycle (
    input wire logic clk,
    input wire logic rst_b,
    input fsp_pkg::fsp_req_t req,
    input wire logic [fsp_pkg::DW-1:0] dq_i,
    output logic done,
    output logic [fsp_pkg::DW-1:0] rdata,
    output fsp_pkg::fsp_pins_t pins
);

    fsp_pkg::fsp_cyc_state_t state_ff, nxt_state;
    fsp_pkg::fsp_pins_t pins_ff, nxt_pins;
    logic [3:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    logic wr_ff, nxt_wr;
    logic [fsp_pkg::DW-1:0] rdata_ff, nxt_rdata;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_wr = wr_ff;
        nxt_rdata = rdata_ff;
        unique case (state_ff)
            fsp_pkg::CYC_IDLE:
            begin
                if (req.valid)
                begin
                    nxt_pins.ce_b = 1'b0;
                    nxt_pins.addr = req.addr;
                    nxt_wr = req.wr;
                    if (req.wr)
                    begin
                        nxt_pins.we_b = 1'b0;
                        nxt_pins.dq_o = req.wdata;
                        nxt_pins.dq_oe = 1'b1;
                        nxt_cnt = `FSP_WE_LOW_CYC;
                    end
                    else
                    begin
                        nxt_pins.oe_b = 1'b0;
                        nxt_cnt = `FSP_RD_ACC_CYC;
                    end
                    nxt_state = fsp_pkg::CYC_ACTIVE;
                end
            end
            fsp_pkg::CYC_ACTIVE:
            begin
                if (cnt_ff == 4'h0)
                begin
                    // sample before the strobes rise so data is still held
                    if (!wr_ff)
                    begin
                        nxt_rdata = dq_i;
                    end
                    nxt_pins.ce_b = 1'b1;
                    nxt_pins.oe_b = 1'b1;
                    nxt_pins.we_b = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = fsp_pkg::CYC_RECOVER;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            fsp_pkg::CYC_RECOVER:
            begin
                // data held one cycle past the write strobe rise
                nxt_pins.dq_oe = 1'b0;
                nxt_state = fsp_pkg::CYC_IDLE;
            end
            default:
            begin
                nxt_state = fsp_pkg::CYC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= fsp_pkg::CYC_IDLE;
            pins_ff <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
            cnt_ff <= 4'h0;
            done_ff <= 1'b0;
            wr_ff <= 1'b0;
            rdata_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            wr_ff <= nxt_wr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign done = done_ff;
    assign rdata = rdata_ff;
    assign pins = pins_ff;

endmodule : fsp_bus_cycle

// ===== rtl/fsp_status_poller.sv
// host side status poller and power-down sequencer for a parallel nor flash
//
// Notes on behaviour
// [R1] completion: read low status byte, data poll bit equal expected bit means pass.
// [R2] mismatch with timeout flag set: read again, pass on match, else fail.
// [R3] program and single sector erase poll at the programmed or sector address.
// [R4] multi-sector and chip erase poll lowest and highest erased sector addresses.
// [R5] flash reports timeout flag at a sector whose erase ran over time.
// [R6] sector toggle bit is ignored once an erase timeout has occurred.
// [R7] write buffer programming polls always at the last written address.
// [R8] write buffer: mismatch with buffer abort flag set means the write aborted.
// [R9] toggle bit compared across two successive reads shows algorithm still running.
// [R10] after timeout flag seen, recheck toggle and poll bits before declaring failure; the recheck here decides on the poll bit only.
// [R11] after deep power-down entry write, wait the maximum entry delay.
// [R12] after release write, wait maximum release time before any further access.
// [R13] flash drives complement of expected bit while busy, true data when done.
// [R14] flash inverts toggle bit each read while busy, stops when done or timed out.
`include "fsp_regs.svh"

module fsp_status_poller #(
    parameter int unsigned TRDP_CYCLES = `FSP_TRDP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output fsp_pkg::fsp_pins_t flash_pins,
    input wire logic [fsp_pkg::DW-1:0] flash_dq_i
);

    // ----------------
    // register bus
    // ----------------
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [fsp_pkg::AW-1:0] addr_a_ff, nxt_addr_a;
    logic [fsp_pkg::AW-1:0] addr_b_ff, nxt_addr_b;
    logic [fsp_pkg::DW-1:0] data_ff, nxt_data;
    logic [3:0] irq_stat_ff, nxt_irq_stat;
    logic [3:0] irq_mask_ff, nxt_irq_mask;
    logic irq_ff, nxt_irq;
    logic commit;
    logic mapped;
    logic [3:0] irq_set;
    logic busy;
    logic [31:0] status_word;

    // write takes effect only at the edge where pready is seen high
    assign commit = psel & penable & pready_ff & pwrite;

    always_comb
    begin
        nxt_pready = psel & penable & ~pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_addr_a = addr_a_ff;
        nxt_addr_b = addr_b_ff;
        nxt_data = data_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        mapped = 1'b1;
        unique case (paddr)
            `FSP_OFF_CMD: nxt_prdata = 32'h0000_0000;
            `FSP_OFF_ADDR_A: nxt_prdata = {7'h00, addr_a_ff};
            `FSP_OFF_ADDR_B: nxt_prdata = {7'h00, addr_b_ff};
            `FSP_OFF_DATA: nxt_prdata = {16'h0000, data_ff};
            `FSP_OFF_STATUS: nxt_prdata = status_word;
            `FSP_OFF_IRQ_STAT: nxt_prdata = {28'h0000000, irq_stat_ff};
            `FSP_OFF_IRQ_MASK: nxt_prdata = {28'h0000000, irq_mask_ff};
            default:
            begin
                nxt_prdata = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
        if (nxt_pready)
        begin
            nxt_pslverr = ~mapped;
        end
        else
        begin
            nxt_prdata = prdata_ff;
        end
        if (commit)
        begin
            unique case (paddr)
                `FSP_OFF_ADDR_A: nxt_addr_a = pwdata[fsp_pkg::AW-1:0];
                `FSP_OFF_ADDR_B: nxt_addr_b = pwdata[fsp_pkg::AW-1:0];
                `FSP_OFF_DATA: nxt_data = pwdata[fsp_pkg::DW-1:0];
                `FSP_OFF_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~pwdata[3:0];
                `FSP_OFF_IRQ_MASK: nxt_irq_mask = pwdata[3:0];
                default: nxt_irq_mask = irq_mask_ff;
            endcase
        end
        // a new event beats a simultaneous clear
        nxt_irq_stat = nxt_irq_stat | irq_set;
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `FSP_RST_WORD;
            addr_a_ff <= '0;
            addr_b_ff <= '0;
            data_ff <= '0;
            irq_stat_ff <= `FSP_RST_IRQ;
            irq_mask_ff <= `FSP_RST_IRQ;
            irq_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            addr_a_ff <= nxt_addr_a;
            addr_b_ff <= nxt_addr_b;
            data_ff <= nxt_data;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
        end
    end

    // ----------------
    // polling and command sequencer
    // ----------------
    fsp_pkg::fsp_state_t state_ff, nxt_state;
    fsp_pkg::fsp_req_t req_ff, nxt_req;
    logic [1:0] mode_ff, nxt_mode;
    logic [1:0] pd_ff, nxt_pd;
    logic sel_b_ff, nxt_sel_b;
    logic abort_ff, nxt_abort;
    logic [12:0] wait_ff, nxt_wait;
    logic [7:0] byte_ff, nxt_byte;
    logic have_prev_ff, nxt_have_prev;
    logic toggle_ff, nxt_toggle;
    logic sect_toggle_ff, nxt_sect_toggle;
    logic timeout_ff, nxt_timeout;
    logic cyc_done;
    logic [fsp_pkg::DW-1:0] cyc_rdata;
    logic [7:0] cur;
    logic match;
    logic start;
    logic [1:0] cmd_op;

    assign cur = cyc_rdata[7:0];
    assign match = cur[`FSP_BIT_DATA_POLL] == data_ff[`FSP_BIT_DATA_POLL]; // [R1] [R13]
    assign cmd_op = pwdata[`FSP_CMD_OP_LSB +: 2];
    assign start = commit & (paddr == `FSP_OFF_CMD) & (state_ff == fsp_pkg::ST_IDLE);
    assign busy = state_ff != fsp_pkg::ST_IDLE;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`FSP_ST_BUSY] = busy; // [R12]
        status_word[`FSP_ST_TOGGLE] = toggle_ff;
        status_word[`FSP_ST_SECT_TOGGLE] = sect_toggle_ff;
        status_word[`FSP_ST_TIMEOUT] = timeout_ff;
        status_word[`FSP_ST_BYTE_LSB +: 8] = byte_ff;
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_req.valid = 1'b0;
        nxt_mode = mode_ff;
        nxt_pd = pd_ff;
        nxt_sel_b = sel_b_ff;
        nxt_abort = abort_ff;
        nxt_wait = wait_ff;
        nxt_byte = byte_ff;
        nxt_have_prev = have_prev_ff;
        nxt_toggle = toggle_ff;
        nxt_sect_toggle = sect_toggle_ff;
        nxt_timeout = timeout_ff;
        irq_set = 4'h0;
        if (cyc_done && !req_ff.wr)
        begin
            nxt_byte = cur;
            nxt_have_prev = 1'b1;
            // two successive reads decide whether the algorithm still runs
            nxt_toggle = have_prev_ff & (cur[`FSP_BIT_TOGGLE] ^ byte_ff[`FSP_BIT_TOGGLE]); // [R9] [R14]
            // sector toggle means nothing once the erase has timed out
            nxt_sect_toggle = have_prev_ff & ~cur[`FSP_BIT_TIMEOUT]
                & (cur[`FSP_BIT_SECT_TOGGLE] ^ byte_ff[`FSP_BIT_SECT_TOGGLE]); // [R6]
            nxt_timeout = cur[`FSP_BIT_TIMEOUT]; // [R5]
        end
        unique case (state_ff)
            fsp_pkg::ST_IDLE:
            begin
                if (start && cmd_op == `FSP_OP_POLL)
                begin
                    nxt_mode = pwdata[`FSP_CMD_MODE_LSB +: 2];
                    nxt_sel_b = 1'b0;
                    nxt_abort = 1'b0;
                    nxt_have_prev = 1'b0;
                    // address a is the program, sector or last buffered address
                    nxt_req = '{valid: 1'b1, wr: 1'b0, addr: addr_a_ff, wdata: '0}; // [R3] [R7]
                    nxt_state = fsp_pkg::ST_POLL;
                end
                else if (start && cmd_op == `FSP_OP_WRITE)
                begin
                    nxt_pd = pwdata[`FSP_CMD_PD_LSB +: 2];
                    nxt_req = '{valid: 1'b1, wr: 1'b1, addr: addr_a_ff, wdata: data_ff};
                    nxt_state = fsp_pkg::ST_CMD;
                end
            end
            fsp_pkg::ST_POLL:
            begin
                if (cyc_done)
                begin
                    if (match)
                    begin
                        irq_set[`FSP_IRQ_PASS] = 1'b1; // [R1]
                        nxt_state = fsp_pkg::ST_IDLE;
                    end
                    else if (mode_ff == `FSP_MODE_WBUF && cur[`FSP_BIT_BUF_ABORT])
                    begin
                        nxt_abort = 1'b1; // [R8]
                        nxt_req.valid = 1'b1;
                        nxt_state = fsp_pkg::ST_RECHK;
                    end
                    else if (cur[`FSP_BIT_TIMEOUT])
                    begin
                        // poll bit may flip together with the timeout flag
                        nxt_req.valid = 1'b1; // [R2] [R10]
                        nxt_state = fsp_pkg::ST_RECHK;
                    end
                    else
                    begin
                        if (mode_ff == `FSP_MODE_MULTI)
                        begin
                            // alternate lowest and highest erased sector
                            nxt_sel_b = ~sel_b_ff; // [R4]
                            nxt_req.addr = sel_b_ff ? addr_a_ff : addr_b_ff; // [R4]
                        end
                        nxt_req.valid = 1'b1;
                    end
                end
            end
            fsp_pkg::ST_RECHK:
            begin
                if (cyc_done)
                begin
                    if (match)
                    begin
                        irq_set[`FSP_IRQ_PASS] = 1'b1; // [R2]
                    end
                    else if (abort_ff)
                    begin
                        irq_set[`FSP_IRQ_ABORT] = 1'b1; // [R8]
                    end
                    else
                    begin
                        irq_set[`FSP_IRQ_FAIL] = 1'b1; // [R2] [R10]
                    end
                    nxt_state = fsp_pkg::ST_IDLE;
                end
            end
            fsp_pkg::ST_CMD:
            begin
                if (cyc_done)
                begin
                    if (pd_ff == `FSP_PD_ENTRY)
                    begin
                        nxt_wait = 13'(`FSP_TDP_CYC); // [R11]
                        nxt_state = fsp_pkg::ST_PD_WAIT;
                    end
                    else if (pd_ff == `FSP_PD_RELEASE)
                    begin
                        nxt_wait = 13'(TRDP_CYCLES); // [R12]
                        nxt_state = fsp_pkg::ST_PD_WAIT;
                    end
                    else
                    begin
                        irq_set[`FSP_IRQ_CMD_DONE] = 1'b1;
                        nxt_state = fsp_pkg::ST_IDLE;
                    end
                end
            end
            fsp_pkg::ST_PD_WAIT:
            begin
                // no new operation is accepted until the latency has run out
                if (wait_ff <= 13'h0001)
                begin
                    irq_set[`FSP_IRQ_CMD_DONE] = 1'b1; // [R11] [R12]
                    nxt_state = fsp_pkg::ST_IDLE;
                end
                else
                begin
                    nxt_wait = wait_ff - 13'h0001;
                end
            end
            default:
            begin
                nxt_state = fsp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= fsp_pkg::ST_IDLE;
            req_ff <= '0;
            mode_ff <= `FSP_MODE_SINGLE;
            pd_ff <= `FSP_PD_NONE;
            sel_b_ff <= 1'b0;
            abort_ff <= 1'b0;
            wait_ff <= 13'h0000;
            byte_ff <= 8'h00;
            have_prev_ff <= 1'b0;
            toggle_ff <= 1'b0;
            sect_toggle_ff <= 1'b0;
            timeout_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            mode_ff <= nxt_mode;
            pd_ff <= nxt_pd;
            sel_b_ff <= nxt_sel_b;
            abort_ff <= nxt_abort;
            wait_ff <= nxt_wait;
            byte_ff <= nxt_byte;
            have_prev_ff <= nxt_have_prev;
            toggle_ff <= nxt_toggle;
            sect_toggle_ff <= nxt_sect_toggle;
            timeout_ff <= nxt_timeout;
        end
    end

    // ----------------
    // flash bus cycles
    // ----------------
    fsp_bus_cycle u_cycle (
        .clk(clk),
        .rst_b(rst_b),
        .req(req_ff),
        .dq_i(flash_dq_i),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .pins(flash_pins)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

endmodule : fsp_status_poller

// ===== testbench/fsp_status_poller_assertions.sv
// concurrent checks on the status poller ports
module fsp_status_poller_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input fsp_pkg::fsp_pins_t flash_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------
    // flash strobe shapes
    // ----------------
    sequence rd_low;
        !flash_pins.oe_b [*5] ##1 flash_pins.oe_b;
    endsequence
    sequence wr_low;
        !flash_pins.we_b [*4] ##1 (flash_pins.we_b && flash_pins.dq_oe);
    endsequence
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_read_width: assert property ($fell(flash_pins.oe_b) |-> rd_low)
        else $error("read strobe width");
    chk_read_gap: assert property ($rose(flash_pins.oe_b) |-> flash_pins.oe_b [*2])
        else $error("read recovery short");
    chk_read_addr: assert property (!flash_pins.oe_b && $past(!flash_pins.oe_b) |-> $stable(flash_pins.addr))
        else $error("address moved in read");
    chk_read_quiet: assert property (!flash_pins.oe_b |-> !flash_pins.dq_oe && flash_pins.we_b && !flash_pins.ce_b)
        else $error("read strobes wrong");
    chk_write_width: assert property ($fell(flash_pins.we_b) |-> wr_low)
        else $error("write strobe width");
    chk_ce_paired: assert property ($fell(flash_pins.ce_b) |-> !flash_pins.oe_b || !flash_pins.we_b)
        else $error("select without strobe");
endmodule : fsp_status_poller_assertions

// ===== testbench/fsp_flash_model.sv
// behavioural flash status source for the poller bench
module fsp_flash_model (
    input wire logic clk,
    input fsp_pkg::fsp_pins_t pins,
    input wire logic clr,
    input wire logic [7:0] busy_reads,
    input wire logic [7:0] true_byte,
    input wire logic to_en,
    input wire logic ab_en,
    input wire logic [fsp_pkg::AW-1:0] to_addr,
    output logic [fsp_pkg::DW-1:0] dq,
    output logic [fsp_pkg::AW-1:0] last_addr,
    output logic [7:0] nreads,
    output logic [fsp_pkg::DW-1:0] last_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl = 1'b0;
    logic prev_oe = 1'b1;
    logic tmo;
    logic [7:0] st;
    logic [15:0] last_dq = 16'h0000;
    always_comb
    begin
        tmo = to_en && (pins.addr == to_addr);
        if (nreads >= busy_reads)
            st = true_byte;
        else
            st = {~true_byte[7], tgl, tmo, 2'b00, tgl, ab_en, 1'b0};
    end
    // released bus shows the inverse, never a stale copy
    assign dq = (!pins.oe_b && !pins.ce_b) ? {8'h00, st} : ~last_dq;
    always @(posedge clk)
    begin
        prev_oe <= pins.oe_b;
        if (!pins.oe_b)
            last_addr <= pins.addr;
        if (!pins.oe_b)
            last_dq <= dq;
        if (!pins.we_b && !pins.ce_b)
            last_wr <= pins.dq_o;
        if (clr)
            nreads <= 8'h00;
        else if (!prev_oe && pins.oe_b)
            nreads <= nreads + 8'h01;
        if (!prev_oe && pins.oe_b)
            tgl <= tgl ^ ~last_dq[5];
    end
endmodule : fsp_flash_model

// ===== testbench/tb_top.sv
// self-checking bench for the status poller
`include "fsp_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [24:0] ADDR_LO = 25'h0001000;
    localparam logic [24:0] ADDR_HI = 25'h0120000;
    localparam logic [31:0] EXP_DATA = 32'h0000_c3a5;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0, to_en = 1'b0, ab_en = 1'b0;
    logic [7:0] paddr = 8'h00, busy_reads = 8'h00, nreads;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, err;
    logic [15:0] dq, last_wr;
    logic [24:0] last_addr;
    fsp_pkg::fsp_pins_t pins;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    fsp_status_poller #(.TRDP_CYCLES(20)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .flash_pins(pins), .flash_dq_i(dq));
    fsp_flash_model u_flash (.clk(clk), .pins(pins), .clr(clr), .busy_reads(busy_reads),
        .true_byte(EXP_DATA[7:0]), .to_en(to_en), .ab_en(ab_en), .to_addr(ADDR_LO), .dq(dq),
        .last_addr(last_addr), .nreads(nreads), .last_wr(last_wr));
    // ----------------
    // shared tasks
    // ----------------
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // ----------------
    // scenarios
    // ----------------
    task automatic regs_after_reset();
        logic [31:0] r;
        logic [7:0] offs [4] = '{`FSP_OFF_CMD, `FSP_OFF_STATUS, `FSP_OFF_IRQ_STAT, `FSP_OFF_IRQ_MASK};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, offs[i], 32'h0, r);
            check(r, `FSP_RST_WORD);
        end
        apb(1'b0, 8'h1c, 32'h0, r);
        check({31'h0, err}, 32'h1);
        apb(1'b1, `FSP_OFF_IRQ_MASK, 32'hf, r);
        apb(1'b1, `FSP_OFF_ADDR_A, {7'h0, ADDR_LO}, r);
        apb(1'b1, `FSP_OFF_ADDR_B, {7'h0, ADDR_HI}, r);
        apb(1'b1, `FSP_OFF_DATA, EXP_DATA, r);
        apb(1'b0, `FSP_OFF_DATA, 32'h0, r);
        check(r, EXP_DATA);
    endtask : regs_after_reset
    task automatic poll(input logic [1:0] mode, input logic [7:0] busy, input logic te,
                        input logic ae, input logic [31:0] exp_irq, input logic [7:0] exp_n,
                        input logic [24:0] exp_addr);
        logic [31:0] r;
        busy_reads <= busy;
        to_en <= te;
        ab_en <= ae;
        clr <= 1'b1;
        apb(1'b1, `FSP_OFF_CMD, {28'h0, mode, `FSP_OP_POLL}, r);
        clr <= 1'b0;
        while (irq !== 1'b1)
            @(posedge clk);
        apb(1'b0, `FSP_OFF_IRQ_STAT, 32'h0, r);
        check(r, exp_irq);
        check({24'h0, nreads}, {24'h0, exp_n});
        check({7'h0, last_addr}, {7'h0, exp_addr});
        apb(1'b0, `FSP_OFF_STATUS, 32'h0, r);
        check(r & ((exp_irq == 32'h1) ? 32'hff09 : 32'h8009),
            (exp_irq == 32'h1) ? 32'ha508 : {28'h0, te, 3'h0});
        apb(1'b1, `FSP_OFF_IRQ_MASK, 32'h0, r);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `FSP_OFF_IRQ_MASK, 32'hf, r);
        apb(1'b1, `FSP_OFF_IRQ_STAT, exp_irq, r);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
    endtask : poll
    task automatic cmd(input logic [1:0] pd, input int min_wait);
        logic [31:0] r;
        int n = 0;
        apb(1'b1, `FSP_OFF_CMD, {26'h0, pd, 2'h0, `FSP_OP_WRITE}, r);
        apb(1'b0, `FSP_OFF_STATUS, 32'h0, r);
        check(r & 32'h1, 32'h1);
        while (irq !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n >= min_wait}, 32'h1);
        check({16'h0, last_wr}, EXP_DATA);
        apb(1'b0, `FSP_OFF_IRQ_STAT, 32'h0, r);
        check(r, 32'h8);
        apb(1'b1, `FSP_OFF_IRQ_STAT, 32'h8, r);
    endtask : cmd
    // hang guard: generous against a run of about a thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        regs_after_reset();
        poll(`FSP_MODE_SINGLE, 8'd3, 1'b0, 1'b0, 32'h1, 8'd4, ADDR_LO);
        poll(`FSP_MODE_SINGLE, 8'd1, 1'b1, 1'b0, 32'h1, 8'd2, ADDR_LO);
        poll(`FSP_MODE_SINGLE, 8'd200, 1'b1, 1'b0, 32'h2, 8'd2, ADDR_LO);
        poll(`FSP_MODE_MULTI, 8'd1, 1'b0, 1'b0, 32'h1, 8'd2, ADDR_HI);
        poll(`FSP_MODE_WBUF, 8'd200, 1'b0, 1'b1, 32'h4, 8'd2, ADDR_LO);
        cmd(`FSP_PD_NONE, 0);
        cmd(`FSP_PD_ENTRY, 500);
        cmd(`FSP_PD_RELEASE, 20);
        wrap_up();
    end
endmodule : tb_top
bind fsp_status_poller fsp_status_poller_assertions u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins));
